// ---- dv/ssmp_prog_asserts.sv ----
/* Port checker of the serial programmer.
   Assumes it is bound to ssmp_programmer and sees only its ports. */
`timescale 1ns/100ps
`default_nettype none
module ssmp_prog_asserts (
    // Clock and reset
    input wire logic               clock,
    input wire logic               reset_n,
    input wire logic               clk_en,
    // Command and answer
    input wire logic               cmd_valid,
    input wire logic               cmd_ready,
    input wire ssmp_pkg::ssmp_op_t cmd_op,
    input wire logic               rsp_valid,
    input wire logic               rsp_err,
    input wire logic               session_active,
    // Target pins
    input wire logic               tgt_reset_n,
    input wire logic               sck,
    input wire logic               mosi
);
    default clocking @(posedge clock); endclocking
    default disable iff (!reset_n);
    // Command taken, and one offered before the session opened
    wire logic take  = clk_en && cmd_valid && cmd_ready;
    wire logic early = take && !session_active && cmd_op > ssmp_pkg::SSMP_OP_END;
    a_pulse_min: assert property ($rose(tgt_reset_n) |-> tgt_reset_n [*8])
        else $error("reset pulse short");
    a_sck_in_reset: assert property ($changed(sck) |-> !tgt_reset_n)
        else $error("link clock moved outside session");
    a_sck_high_min: assert property ($rose(sck) |-> sck [*4])
        else $error("link clock high phase short");
    a_sck_low_min: assert property ($fell(sck) |-> !sck [*4])
        else $error("link clock low phase short");
    a_mosi_while_low: assert property ($changed(mosi) |-> !sck)
        else $error("data moved while clock high");
    a_early_refused: assert property (early |-> ##[1:3] rsp_valid && rsp_err)
        else $error("early command not refused");
    a_early_quiet: assert property (early |=> $stable(sck) [*3])
        else $error("early command moved pins");
    a_session_low: assert property (session_active |-> !tgt_reset_n)
        else $error("session open with reset high");
    a_take_busy: assert property (take |=> !cmd_ready && !rsp_valid)
        else $error("ready stayed high after take");
    // Main scenarios
    c_start: cover property ($rose(session_active));
    c_refuse: cover property (rsp_valid && rsp_err);
    c_done: cover property (rsp_valid && !rsp_err && session_active);
endmodule
bind ssmp_programmer ssmp_prog_asserts u_asserts (.clock(clock), .reset_n(reset_n),
    .clk_en(clk_en), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op),
    .rsp_valid(rsp_valid), .rsp_err(rsp_err), .session_active(session_active),
    .tgt_reset_n(tgt_reset_n), .sck(sck), .mosi(mosi));
`default_nettype wire

// ---- dv/ssmp_target_model.sv ----
/* Behavioural target of the serial programming port.
   Assumes the programmer drives reset, link clock and data. */
`timescale 1ns/100ps
`default_nettype none
module ssmp_target_model #(
    parameter int BUSY_NS = 20000
) (
    // Target pins
    input  wire logic tgt_reset_n,
    input  wire logic sck,
    input  wire logic mosi,
    output var  logic miso
);
    logic [31:0] sh;
    logic [7:0]  out;
    logic [7:0]  rd;
    logic [7:0]  fl[int] = '{default: 8'hFF};
    logic [7:0]  ee[int] = '{default: 8'hFF};
    logic [7:0]  pb[int];
    int          n = 0;
    bit          en = 0;
    bit          lost = 1;
    realtime     rdy_t = 0;
    initial miso = 1'b0;
    // Reset edges restart framing and invert miso; release ends the session
    always @(tgt_reset_n) begin
        n = 0;
        en = en && !tgt_reset_n;
        miso = ~miso;
    end
    // Sample on rising edge; answer byte loaded at byte boundaries
    always @(posedge sck) if (!tgt_reset_n) begin
        sh = {sh[30:0], mosi};
        n = n + 1;
        rd = sh[23:16] == 8'hA0 ? ee[sh[9:0]] : fl[{sh[13:0], sh[19]}];
        if (n % 8 == 0) out = n == 16 && !lost ? sh[7:0] : (n == 24 && $realtime >= rdy_t ? rd : 8'hFF);
        if (n == 32) begin
            n = 0;
            lost = 0; // First enable goes unanswered
            if (sh[31:16] == 16'hAC53) en = 1;
            if (en && sh[31:21] == 11'h564) begin
                fl.delete();
                ee.delete();
                rdy_t = $realtime + BUSY_NS;
            end
            if (en && sh[31:24] == 8'h4C) begin
                foreach (pb[k]) fl[{sh[21:14], k[6:0]}] = pb[k];
                rdy_t = $realtime + BUSY_NS;
            end else if (en && (sh[31:24] & 8'hF7) == 8'h40) pb[{sh[13:8], sh[27]}] = sh[7:0];
            if (en && sh[31:24] == 8'hC0) begin
                ee[sh[17:8]] = sh[7:0];
                rdy_t = $realtime + BUSY_NS;
            end
        end
    end
    // Shift the answer out on the falling edge
    always @(negedge sck) if (!tgt_reset_n) begin
        miso = out[7];
        out = {out[6:0], 1'b0};
    end
endmodule
`default_nettype wire

// ---- dv/tb_top.sv ----
/* Bench of the programmer against the behavioural target.
   Assumes the checker binds itself to the programmer. */
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    logic               clock = 1'b0;
    logic               reset_n, cmd_valid, cmd_high, cmd_ready, rsp_valid, rsp_err;
    logic               session_active, tgt_reset_n, sck, mosi, miso;
    logic               clk_en = 1'b1;
    ssmp_pkg::ssmp_op_t cmd_op;
    logic [13:0]        cmd_addr, pa, ea;
    logic [7:0]         cmd_data, rsp_data, ed;
    logic [7:0]         pd[8];
    logic [15:0]        rnd = 16'h0B44, ern = 16'h0B44;
    int                 fails = 0;
    int                 comparisons = 0;
    always #25 clock = ~clock;
    ssmp_programmer #(.T_PWR_CYC(50), .T_FLASH_CYC(500), .T_EE_CYC(1000), .T_ERASE_CYC(500)
        ) dut (.clock(clock), .reset_n(reset_n), .clk_en(clk_en),
        .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_high(cmd_high),
        .cmd_addr(cmd_addr), .cmd_data(cmd_data), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
        .rsp_err(rsp_err), .session_active(session_active), .tgt_reset_n(tgt_reset_n),
        .sck(sck), .mosi(mosi), .miso(miso));
    ssmp_target_model u_target (.tgt_reset_n(tgt_reset_n), .sck(sck),
        .mosi(mosi), .miso(miso));
    // Random source
    function automatic logic [15:0] next_rnd(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    // Random one-in-eight freezes, only inside a session
    always @(posedge clock) begin
        ern    <= next_rnd(ern);
        clk_en <= !session_active || ern[2:0] != 3'h0;
    end
    task automatic complete_run;
        $display("fails %0d comparisons %0d", fails, comparisons);
        if (fails == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    // One command: offer, await the answer pulse, check error and optional data
    task automatic run(input ssmp_pkg::ssmp_op_t op, input logic h, input logic [13:0] a,
                       input logic [7:0] d, input logic e_err, input logic [8:0] e_dat);
        int j;
        int k;
        cmd_valid <= 1'b1;
        cmd_op    <= op;
        cmd_high  <= h;
        cmd_addr  <= a;
        cmd_data  <= d;
        @(posedge clock);
        // Hold the request until the edge that takes it
        for (j = 0; j < 100 && (clk_en !== 1'b1 || cmd_ready !== 1'b1); j++) @(posedge clock);
        cmd_valid <= 1'b0;
        @(negedge clock);
        for (k = 0; k < 5000 && rsp_valid !== 1'b1; k++) @(negedge clock);
        if (j == 100 || k == 5000) begin
            fails++;
            complete_run();
        end
        check("rsp_err", {7'h00, e_err}, {7'h00, rsp_err});
        if (e_dat[8]) check("rsp_data", e_dat[7:0], rsp_data);
        @(posedge clock);
    endtask
    // Main sequence
    initial begin
        reset_n = 1'b0;
        cmd_valid = 1'b0;
        cmd_op = ssmp_pkg::SSMP_OP_START;
        cmd_high = 1'b0;
        cmd_addr = 14'h0000;
        cmd_data = 8'h00;
        repeat (5) @(posedge clock);
        reset_n <= 1'b1;
        @(posedge clock);
        check("reset and sck", 8'h00, {6'h00, tgt_reset_n, sck});
        for (int i = 2; i < 8; i++) run(ssmp_pkg::ssmp_op_t'(i), 0, 0, 0, 1, 0);
        run(ssmp_pkg::SSMP_OP_START, 0, 0, 0, 0, 0);
        check("session", 8'h01, {7'h00, session_active});
        run(ssmp_pkg::SSMP_OP_ERASE, 0, 0, 0, 0, 0);
        rnd = next_rnd(rnd);
        pa = {rnd[7:0], 6'h00};
        run(ssmp_pkg::SSMP_OP_RFLASH, 1, pa | 14'h0005, 0, 0, 9'h1FF);
        run(ssmp_pkg::SSMP_OP_REE, 0, {4'h0, rnd[15:6]}, 0, 0, 9'h1FF);
        run(ssmp_pkg::SSMP_OP_LOAD, 1, pa | 14'h0005, 8'h11, 1, 0);
        // Four words of one page, low byte before high byte
        for (int i = 0; i < 8; i++) begin
            rnd = next_rnd(rnd);
            pd[i] = rnd[7:0];
            run(ssmp_pkg::SSMP_OP_LOAD, i[0], pa | 14'(i >> 1), pd[i], 0, 0);
        end
        run(ssmp_pkg::SSMP_OP_WPAGE, 0, pa, 0, 0, 0);
        for (int i = 0; i < 8; i++) begin
            run(ssmp_pkg::SSMP_OP_RFLASH, i[0], pa | 14'(i >> 1), 0, 0, {1'b1, pd[i]});
        end
        // EEPROM bytes without erase, the last one all ones
        for (int i = 0; i < 3; i++) begin
            rnd = next_rnd(rnd);
            ed = (i == 2) ? 8'hFF : rnd[7:0];
            ea = {4'h0, rnd[15:6]};
            run(ssmp_pkg::SSMP_OP_WEE, 0, ea, ed, 0, 0);
            run(ssmp_pkg::SSMP_OP_REE, 0, ea, 0, 0, {1'b1, ed});
        end
        run(ssmp_pkg::SSMP_OP_END, 0, 0, 0, 0, 0);
        check("reset and session", 8'h02, {6'h00, tgt_reset_n, session_active});
        run(ssmp_pkg::SSMP_OP_REE, 0, ea, 0, 1, 0);
        run(ssmp_pkg::SSMP_OP_START, 0, 0, 0, 0, 0);
        run(ssmp_pkg::SSMP_OP_RFLASH, 0, pa, 0, 0, {1'b1, pd[0]});
        complete_run();
    end
endmodule
`default_nettype wire

// ---- logic/ssmp_defs.svh ----
/*
 * Constants of the serial memory programming controller: instruction bytes,
 * field positions and timing figures.
 * Assumes a 20 MHz controller clock and a target that decodes four-byte words.
 */
`ifndef SSMP_DEFS_SVH
`define SSMP_DEFS_SVH

// Controller clock
`define SSMP_CLK_MHZ        20

// Timing figures in their own units
`define SSMP_T_PWR_MS       20.0
`define SSMP_T_FLASH_MS     4.5
`define SSMP_T_EEPROM_MS    9.0
`define SSMP_T_ERASE_MS     9.0
`define SSMP_T_RSTP_NS      1000.0
`define SSMP_SCK_HALF_CYC   4

// Instruction bytes
`define SSMP_PEN_B1         8'hAC
`define SSMP_PEN_B2         8'h53
`define SSMP_ERASE_B2       8'h80
`define SSMP_LOAD_B1        8'h40
`define SSMP_WPAGE_B1       8'h4C
`define SSMP_RFLASH_B1      8'h20
`define SSMP_REE_B1         8'hA0
`define SSMP_WEE_B1         8'hC0
`define SSMP_HIGH_BIT       3
`define SSMP_ALL_ONES       8'hFF

// Field positions of the flash word address
`define SSMP_WORD_LSB       0
`define SSMP_WORD_W         6
`define SSMP_PAGE_LSB       6
`define SSMP_PAGE_W         8

`endif

// ---- logic/ssmp_pkg.sv ----
/*
 * Types of the serial memory programming controller.
 * Assumes ssmp_defs.svh supplies every number.
 */
`default_nettype none
package ssmp_pkg;

    // Commands accepted on the user port
    typedef enum logic [2:0] {
        SSMP_OP_START  = 3'h0,
        SSMP_OP_END    = 3'h1,
        SSMP_OP_ERASE  = 3'h2,
        SSMP_OP_LOAD   = 3'h3,
        SSMP_OP_WPAGE  = 3'h4,
        SSMP_OP_RFLASH = 3'h5,
        SSMP_OP_WEE    = 3'h6,
        SSMP_OP_REE    = 3'h7
    } ssmp_op_t;

    // Sequencer states
    typedef enum logic [2:0] {
        SSMP_ST_IDLE   = 3'h0,
        SSMP_ST_RST_HI = 3'h1,
        SSMP_ST_PWR    = 3'h2,
        SSMP_ST_XFER   = 3'h3,
        SSMP_ST_WAIT   = 3'h4,
        SSMP_ST_RESP   = 3'h5
    } ssmp_state_t;

endpackage
`default_nettype wire

// ---- logic/ssmp_programmer.sv ----
/*
 * In-system programmer for a serial-programmable memory target: takes user
 * commands, runs the target's reset pin and four-byte instructions, and
 * waits or polls after each write.
 * Assumes the target core clock runs, and that one command is given at a
 * time through a valid/ready handshake.
 */
`timescale 1ns/100ps
`default_nettype none
`include "ssmp_defs.svh"

module ssmp_programmer #(
    parameter int unsigned T_PWR_CYC   = $rtoi($ceil(`SSMP_T_PWR_MS * `SSMP_CLK_MHZ * 1000.0)),
    parameter int unsigned T_FLASH_CYC =
        $rtoi($ceil(`SSMP_T_FLASH_MS * `SSMP_CLK_MHZ * 1000.0)),
    parameter int unsigned T_EE_CYC    =
        $rtoi($ceil(`SSMP_T_EEPROM_MS * `SSMP_CLK_MHZ * 1000.0)),
    parameter int unsigned T_ERASE_CYC =
        $rtoi($ceil(`SSMP_T_ERASE_MS * `SSMP_CLK_MHZ * 1000.0)),
    parameter int unsigned SCK_HALF    = `SSMP_SCK_HALF_CYC,
    parameter int unsigned RETRIES     = 3
) (
    // Clock and reset
    input  wire logic             clock,
    input  wire logic             reset_n,
    input  wire logic             clk_en,
    // Command port
    input  wire logic             cmd_valid,
    output var  logic             cmd_ready,
    input  wire ssmp_pkg::ssmp_op_t cmd_op,
    input  wire logic             cmd_high,
    input  wire logic [13:0]      cmd_addr,
    input  wire logic [7:0]       cmd_data,
    // Answer port
    output var  logic             rsp_valid,
    output var  logic [7:0]       rsp_data,
    output var  logic             rsp_err,
    output var  logic             session_active,
    // Target pins
    output var  logic             tgt_reset_n,
    output var  logic             sck,
    output var  logic             mosi,
    input  wire logic             miso
);
    localparam int unsigned TW = 20;
    localparam logic [TW-1:0] T_RSTP =
        TW'($rtoi($ceil(`SSMP_T_RSTP_NS * `SSMP_CLK_MHZ / 1000.0)));

    ssmp_shift_if sh_if ();

    ssmp_pkg::ssmp_state_t st_ff, nxt_st;
    ssmp_pkg::ssmp_op_t    op_ff, nxt_op;
    logic          high_ff, nxt_high;
    logic [13:0]   addr_ff, nxt_addr;
    logic [7:0]    data_ff, nxt_data;
    logic [TW-1:0] tmr_ff, nxt_tmr;
    logic [1:0]    try_ff, nxt_try;
    logic          poll_ff, nxt_poll;
    logic          ok_ff, nxt_ok;
    logic          low_vld_ff, nxt_low_vld;
    logic [5:0]    low_word_ff, nxt_low_word;
    logic          ready_ff, nxt_ready;
    logic          rvld_ff, nxt_rvld;
    logic [7:0]    rdata_ff, nxt_rdata;
    logic          rerr_ff, nxt_rerr;
    logic          rst_n_ff, nxt_rst_n;
    logic          start_ff, nxt_start;
    logic [31:0]   word_ff, nxt_word;

    // Four-byte instruction for an operation
    function automatic logic [31:0] build_word(input ssmp_pkg::ssmp_op_t op,
                                               input logic high,
                                               input logic [13:0] addr,
                                               input logic [7:0] data);
        logic [7:0] hb;
        hb = {7'h00, high} << `SSMP_HIGH_BIT;
        case (op)
            ssmp_pkg::SSMP_OP_START:
                build_word = {`SSMP_PEN_B1, `SSMP_PEN_B2, 16'h0000};
            ssmp_pkg::SSMP_OP_ERASE:
                build_word = {`SSMP_PEN_B1, `SSMP_ERASE_B2, 16'h0000};
            ssmp_pkg::SSMP_OP_LOAD:
                build_word = {`SSMP_LOAD_B1 | hb, 8'h00,
                              2'b00, addr[`SSMP_WORD_LSB +: `SSMP_WORD_W], data};
            ssmp_pkg::SSMP_OP_WPAGE:
                build_word = {`SSMP_WPAGE_B1, 2'b00, addr[13:8],
                              addr[7:6], 6'h00, 8'h00};
            ssmp_pkg::SSMP_OP_RFLASH:
                build_word = {`SSMP_RFLASH_B1 | hb, 2'b00, addr[13:0], 8'h00};
            ssmp_pkg::SSMP_OP_WEE:
                build_word = {`SSMP_WEE_B1, 6'h00, addr[9:0], data};
            ssmp_pkg::SSMP_OP_REE:
                build_word = {`SSMP_REE_B1, 6'h00, addr[9:0], 8'h00};
            default:
                build_word = 32'h0000_0000;
        endcase
    endfunction

    // Sequencer next values
    always_comb begin
        nxt_st       = st_ff;
        nxt_op       = op_ff;
        nxt_high     = high_ff;
        nxt_addr     = addr_ff;
        nxt_data     = data_ff;
        nxt_tmr      = (tmr_ff != '0) ? tmr_ff - TW'(1) : tmr_ff;
        nxt_try      = try_ff;
        nxt_poll     = poll_ff;
        nxt_ok       = ok_ff;
        nxt_low_vld  = low_vld_ff;
        nxt_low_word = low_word_ff;
        nxt_ready    = ready_ff;
        nxt_rvld     = 1'b0;
        nxt_rdata    = rdata_ff;
        nxt_rerr     = rerr_ff;
        nxt_rst_n    = rst_n_ff;
        nxt_start    = 1'b0;
        nxt_word     = word_ff;
        case (st_ff)
            ssmp_pkg::SSMP_ST_IDLE: begin
                if (cmd_valid && ready_ff) begin
                    nxt_ready = 1'b0;
                    nxt_op    = cmd_op;
                    nxt_high  = cmd_high;
                    nxt_addr  = cmd_addr;
                    nxt_data  = cmd_data;
                    nxt_poll  = 1'b0;
                    nxt_rdata = 8'h00;
                    nxt_rerr  = 1'b0;
                    nxt_word  = build_word(cmd_op, cmd_high, cmd_addr, cmd_data);
                    if (cmd_op == ssmp_pkg::SSMP_OP_START) begin
                        // Reset pulse then power-up wait
                        nxt_try   = 2'(RETRIES);
                        nxt_rst_n = 1'b1;
                        nxt_tmr   = T_RSTP;
                        nxt_st    = ssmp_pkg::SSMP_ST_RST_HI;
                    end else if (cmd_op == ssmp_pkg::SSMP_OP_END) begin
                        nxt_rst_n   = 1'b1;
                        nxt_ok      = 1'b0;
                        nxt_low_vld = 1'b0;
                        nxt_st      = ssmp_pkg::SSMP_ST_RESP;
                    end else if (!ok_ff) begin
                        nxt_rerr = 1'b1;
                        nxt_st   = ssmp_pkg::SSMP_ST_RESP;
                    end else if (cmd_op == ssmp_pkg::SSMP_OP_LOAD && cmd_high &&
                                 !(low_vld_ff &&
                                   low_word_ff == cmd_addr[`SSMP_WORD_LSB +: `SSMP_WORD_W]))
                    begin
                        nxt_rerr = 1'b1;
                        nxt_st   = ssmp_pkg::SSMP_ST_RESP;
                    end else begin
                        nxt_start = 1'b1;
                        nxt_st    = ssmp_pkg::SSMP_ST_XFER;
                    end
                end
            end
            ssmp_pkg::SSMP_ST_RST_HI: begin
                if (tmr_ff == '0) begin
                    nxt_rst_n = 1'b0;
                    nxt_tmr   = TW'(T_PWR_CYC);
                    nxt_st    = ssmp_pkg::SSMP_ST_PWR;
                end
            end
            ssmp_pkg::SSMP_ST_PWR: begin
                if (tmr_ff == '0) begin
                    nxt_start = 1'b1;
                    nxt_st    = ssmp_pkg::SSMP_ST_XFER;
                end
            end
            ssmp_pkg::SSMP_ST_XFER: begin
                if (sh_if.done) begin
                    nxt_rdata = sh_if.rx_word[7:0];
                    nxt_st    = ssmp_pkg::SSMP_ST_RESP;
                    case (op_ff)
                        ssmp_pkg::SSMP_OP_START: begin
                            // Echo arrives in the third byte
                            if (sh_if.rx_word[15:8] == `SSMP_PEN_B2) begin
                                nxt_ok = 1'b1;
                            end else if (try_ff != 2'b00) begin
                                nxt_try   = try_ff - 2'b01;
                                nxt_rst_n = 1'b1;
                                nxt_tmr   = T_RSTP;
                                nxt_st    = ssmp_pkg::SSMP_ST_RST_HI;
                            end else begin
                                nxt_rerr = 1'b1;
                            end
                        end
                        ssmp_pkg::SSMP_OP_ERASE: begin
                            nxt_low_vld = 1'b0;
                            nxt_tmr     = TW'(T_ERASE_CYC);
                            nxt_st      = ssmp_pkg::SSMP_ST_WAIT;
                        end
                        ssmp_pkg::SSMP_OP_LOAD: begin
                            nxt_low_vld  = !high_ff;
                            nxt_low_word = addr_ff[`SSMP_WORD_LSB +: `SSMP_WORD_W];
                        end
                        ssmp_pkg::SSMP_OP_WPAGE: begin
                            // Full delay, no polling
                            nxt_low_vld = 1'b0;
                            nxt_tmr     = TW'(T_FLASH_CYC);
                            nxt_st      = ssmp_pkg::SSMP_ST_WAIT;
                        end
                        ssmp_pkg::SSMP_OP_WEE: begin
                            if (!poll_ff) begin
                                nxt_tmr = TW'(T_EE_CYC);
                                if (data_ff == `SSMP_ALL_ONES) begin
                                    nxt_st = ssmp_pkg::SSMP_ST_WAIT;
                                end else begin
                                    nxt_poll  = 1'b1;
                                    nxt_word  = build_word(ssmp_pkg::SSMP_OP_REE,
                                                           1'b0, addr_ff, 8'h00);
                                    nxt_start = 1'b1;
                                    nxt_st    = ssmp_pkg::SSMP_ST_XFER;
                                end
                            end else if (sh_if.rx_word[7:0] != data_ff &&
                                         tmr_ff != '0) begin
                                // Still all ones while busy
                                nxt_start = 1'b1;
                                nxt_st    = ssmp_pkg::SSMP_ST_XFER;
                            end
                        end
                        default: begin
                        end
                    endcase
                end
            end
            ssmp_pkg::SSMP_ST_WAIT: begin
                if (tmr_ff == '0) begin
                    nxt_st = ssmp_pkg::SSMP_ST_RESP;
                end
            end
            ssmp_pkg::SSMP_ST_RESP: begin
                nxt_rvld  = 1'b1;
                nxt_ready = 1'b1;
                nxt_st    = ssmp_pkg::SSMP_ST_IDLE;
            end
            default: begin
                nxt_st = ssmp_pkg::SSMP_ST_IDLE;
            end
        endcase
    end

    // Sequencer registers; target reset low from power-up
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            st_ff       <= ssmp_pkg::SSMP_ST_IDLE;
            op_ff       <= ssmp_pkg::SSMP_OP_START;
            high_ff     <= 1'b0;
            addr_ff     <= 14'h0000;
            data_ff     <= 8'h00;
            tmr_ff      <= '0;
            try_ff      <= 2'b00;
            poll_ff     <= 1'b0;
            ok_ff       <= 1'b0;
            low_vld_ff  <= 1'b0;
            low_word_ff <= 6'h00;
            ready_ff    <= 1'b1;
            rvld_ff     <= 1'b0;
            rdata_ff    <= 8'h00;
            rerr_ff     <= 1'b0;
            rst_n_ff    <= 1'b0;
            start_ff    <= 1'b0;
            word_ff     <= 32'h0000_0000;
        end else if (clk_en) begin
            st_ff       <= nxt_st;
            op_ff       <= nxt_op;
            high_ff     <= nxt_high;
            addr_ff     <= nxt_addr;
            data_ff     <= nxt_data;
            tmr_ff      <= nxt_tmr;
            try_ff      <= nxt_try;
            poll_ff     <= nxt_poll;
            ok_ff       <= nxt_ok;
            low_vld_ff  <= nxt_low_vld;
            low_word_ff <= nxt_low_word;
            ready_ff    <= nxt_ready;
            rvld_ff     <= nxt_rvld;
            rdata_ff    <= nxt_rdata;
            rerr_ff     <= nxt_rerr;
            rst_n_ff    <= nxt_rst_n;
            start_ff    <= nxt_start;
            word_ff     <= nxt_word;
        end
    end

    // Shifter request, word taken from its register
    assign sh_if.start   = start_ff;
    assign sh_if.tx_word = word_ff;

    // Link clock half phase held above the target minimum
    ssmp_shifter #(
        .HALF_CYC (SCK_HALF)
    ) u_shifter (
        .clock   (clock),
        .reset_n (reset_n),
        .clk_en  (clk_en),
        .sh      (sh_if.shft),
        .sck     (sck),
        .mosi    (mosi),
        .miso    (miso)
    );

    // Outputs straight from registers
    assign cmd_ready      = ready_ff;
    assign rsp_valid      = rvld_ff;
    assign rsp_data       = rdata_ff;
    assign rsp_err        = rerr_ff;
    assign session_active = ok_ff;
    assign tgt_reset_n    = rst_n_ff;

endmodule

`default_nettype wire

// ---- logic/ssmp_shift_if.sv ----
/*
 * Carrier between the sequencer and the 32-bit serial shifter.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/100ps
`default_nettype none

interface ssmp_shift_if;
    logic        start;
    logic [31:0] tx_word;
    logic        done;
    logic [31:0] rx_word;

    modport ctrl (output start, output tx_word, input done, input rx_word);
    modport shft (input start, input tx_word, output done, output rx_word);
endinterface

`default_nettype wire

// ---- logic/ssmp_shifter.sv ----
/*
 * Serial shifter: makes the link clock by division and moves one 32-bit
 * instruction word, most significant bit first.
 * Assumes the target samples on the rising link clock edge and shifts its
 * answer on the falling edge.
 */
`timescale 1ns/100ps
`default_nettype none
`include "ssmp_defs.svh"

module ssmp_shifter #(
    parameter int unsigned HALF_CYC = `SSMP_SCK_HALF_CYC
) (
    // Clock and reset
    input  wire logic   clock,
    input  wire logic   reset_n,
    input  wire logic   clk_en,
    // Sequencer side
    ssmp_shift_if.shft  sh,
    // Link pins
    output var  logic   sck,
    output var  logic   mosi,
    input  wire logic   miso
);
    logic        busy_ff, nxt_busy;
    logic        sck_ff, nxt_sck;
    logic        mosi_ff, nxt_mosi;
    logic        done_ff, nxt_done;
    logic [7:0]  half_ff, nxt_half;
    logic [4:0]  bit_ff, nxt_bit;
    logic [31:0] tx_ff, nxt_tx;
    logic [31:0] rx_ff, nxt_rx;
    logic        miso_m_ff, miso_s_ff;

    // Pin synchroniser on the answer line
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            miso_m_ff <= 1'b0;
            miso_s_ff <= 1'b0;
        end else if (clk_en) begin
            miso_m_ff <= miso;
            miso_s_ff <= miso_m_ff;
        end
    end

    // Next values of the shift engine
    always_comb begin
        nxt_busy = busy_ff;
        nxt_sck  = sck_ff;
        nxt_mosi = mosi_ff;
        nxt_done = 1'b0;
        nxt_half = half_ff;
        nxt_bit  = bit_ff;
        nxt_tx   = tx_ff;
        nxt_rx   = rx_ff;
        if (busy_ff) begin
            if (half_ff == 8'(HALF_CYC - 1)) begin
                nxt_half = 8'h00;
                if (!sck_ff) begin
                    nxt_sck = 1'b1;             // Data stable here
                end else begin
                    // Sample late in the high phase, after the target shifted
                    nxt_rx  = {rx_ff[30:0], miso_s_ff};
                    nxt_sck = 1'b0;
                    if (bit_ff == 5'h1F) begin
                        nxt_busy = 1'b0;
                        nxt_done = 1'b1;
                    end else begin
                        nxt_bit  = bit_ff + 5'h01;
                        nxt_tx   = {tx_ff[30:0], 1'b0};
                        nxt_mosi = tx_ff[30];
                    end
                end
            end else begin
                nxt_half = half_ff + 8'h01;
            end
        end else if (sh.start) begin
            nxt_busy = 1'b1;
            nxt_tx   = sh.tx_word;
            nxt_mosi = sh.tx_word[31];
            nxt_bit  = 5'h00;
            nxt_half = 8'h00;
        end
    end

    // Shift engine registers
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            busy_ff <= 1'b0;
            sck_ff  <= 1'b0;
            mosi_ff <= 1'b0;
            done_ff <= 1'b0;
            half_ff <= 8'h00;
            bit_ff  <= 5'h00;
            tx_ff   <= 32'h0000_0000;
            rx_ff   <= 32'h0000_0000;
        end else if (clk_en) begin
            busy_ff <= nxt_busy;
            sck_ff  <= nxt_sck;
            mosi_ff <= nxt_mosi;
            done_ff <= nxt_done;
            half_ff <= nxt_half;
            bit_ff  <= nxt_bit;
            tx_ff   <= nxt_tx;
            rx_ff   <= nxt_rx;
        end
    end

    assign sck        = sck_ff;
    assign mosi       = mosi_ff;
    assign sh.done    = done_ff;
    assign sh.rx_word = rx_ff;

endmodule

`default_nettype wire
